// ### rtl/aiss_seq.sv
// analog input scan sequencer: free-running scans of 8 base channels
// plus one expander channel when expanders exist; assumes one clock, front end gives done
// How it works
// R01 - each scan: eight base, plus one expander when expanders exist
// R02 - next scan advances expander channel
// R03 - after sixteen, move to next module
// R04 - pointer wraps after all expander channels
// R05 - no expanders: scan every 2.4 ms
// R06 - expanders present: scan every 2.8 ms
// R07 - expander channel refresh 2.8 ms times sixteen times N
// R08 - free running, no external trigger
// R09 - all sixteen channels converted, used or not
// R10 - expander muxes one input at a time
// R11 - zero to seven expanders supported
// R12 - expander selection commanded to expanders
// R13 - expander results numbered from nine upward
// R14 - results are sixteen-bit two's complement
// R15 - reset clears pointers to first channel
`timescale 1ns/1ps
`default_nettype none
module aiss_seq
    import aiss_pkg::*;
#(
    parameter int SCAN_NOEXP = aiss_pkg::SCAN_CYC_NOEXP,
    parameter int SCAN_EXP   = aiss_pkg::SCAN_CYC_EXP
) (
    // clock and reset
    input  wire logic                 i_sys_clk,
    input  wire logic                 i_rstn,
    // configuration
    input  wire logic [2:0]           i_num_exp,
    // front end
    output logic                      o_req,
    output logic                      o_req_exp,
    output logic [2:0]                o_req_base_ch,
    output logic [2:0]                o_req_exp_mod,
    output logic [3:0]                o_req_exp_ch,
    input  wire logic                 i_done,
    input  wire logic [15:0]          i_data,
    // results
    output logic                      o_res_valid,
    output logic [aiss_pkg::LCH_W-1:0] o_res_chan,
    output logic signed [aiss_pkg::RES_W-1:0] o_res_data,
    output logic                      o_scan_start
);
    import aiss_pkg::*;

    // refuse periods too short to hold one full scan of requests
    if (SCAN_NOEXP < 2 * (BASE_CH + 1) || SCAN_EXP < SCAN_NOEXP) begin : g_chk
        $error("scan periods too short");
    end

    typedef enum logic [1:0] {AISS_IDLE, AISS_REQ, AISS_WAIT} aiss_st_t;

    aiss_conv_if cv ();

    aiss_conv_port u_port (
        .i_sys_clk     (i_sys_clk),
        .i_rstn        (i_rstn),
        .cv            (cv),
        .o_req         (o_req),
        .o_req_exp     (o_req_exp),
        .o_req_base_ch (o_req_base_ch),
        .o_req_exp_mod (o_req_exp_mod),
        .o_req_exp_ch  (o_req_exp_ch),
        .i_done        (i_done),
        .i_data        (i_data)
    );

    aiss_st_t    st, next_st;
    logic [31:0] tmr, next_tmr;
    logic [3:0]  slot, next_slot;
    logic [2:0]  emod, next_emod;
    logic [3:0]  ech, next_ech;
    logic        rv, next_rv;
    logic [LCH_W-1:0] rch, next_rch;
    logic [RES_W-1:0] rdat, next_rdat;
    logic        sst, next_sst;
    logic [31:0] period;
    logic        has_exp;
    logic        slots_done;

    assign has_exp = (i_num_exp != 3'h0); // [R11]
    // period is chosen by expander presence [R05] [R06]
    assign period  = has_exp ? SCAN_EXP : SCAN_NOEXP;
    // last slot is the expander slot when expanders exist [R01]
    assign slots_done = has_exp ? (slot == 4'(BASE_CH))
                                : (slot == 4'(BASE_CH - 1));

    always_comb begin
        next_st   = st;
        next_tmr  = tmr + 32'h0000_0001;
        next_slot = slot;
        next_emod = emod;
        next_ech  = ech;
        next_rv   = 1'b0;
        next_rch  = rch;
        next_rdat = rdat;
        next_sst  = 1'b0;
        // free-running scan tick, no trigger input [R08]
        if (tmr >= period - 32'h0000_0001) begin
            next_tmr  = 32'h0000_0000;
            next_st   = AISS_REQ;
            next_slot = 4'h0;
            next_sst  = 1'b1;
        end
        case (st)
            AISS_IDLE: ;
            // leave only once the request has really been issued
            AISS_REQ:  if (!sst && !next_sst) next_st = AISS_WAIT;
            AISS_WAIT: begin
                if (cv.done) begin
                    next_rv   = 1'b1;
                    next_rdat = cv.data; // [R14]
                    if (slot == 4'(BASE_CH)) begin
                        // expander numbering by chain position [R13]
                        next_rch = LCH_W'(FIRST_EXP_LCH)
                                 + LCH_W'({emod, 4'h0}) + LCH_W'(ech);
                        // advance pointer, all channels [R02] [R09]
                        if (ech == EXP_CH_LAST) begin
                            next_ech = 4'h0;
                            // next module or wrap [R03] [R04] [R07]
                            if (emod + 3'h1 >= i_num_exp)
                                next_emod = 3'h0;
                            else
                                next_emod = emod + 3'h1;
                        end else begin
                            next_ech = ech + 4'h1;
                        end
                    end else begin
                        next_rch = LCH_W'(slot) + LCH_W'(1);
                    end
                    if (!next_sst) begin
                        next_st   = slots_done ? AISS_IDLE : AISS_REQ;
                        next_slot = slot + 4'h1;
                    end
                end
            end
            default: next_st = AISS_IDLE;
        endcase
        if (!has_exp) begin
            next_emod = 3'h0;
            next_ech  = 4'h0;
        end else if (emod >= i_num_exp) begin
            next_emod = 3'h0;
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            st   <= AISS_IDLE;
            tmr  <= 32'h0000_0000;
            slot <= 4'h0;
            emod <= 3'h0; // [R15]
            ech  <= 4'h0; // [R15]
            rv   <= 1'b0;
            rch  <= '0;
            rdat <= '0;
            sst  <= 1'b0;
        end else begin
            st   <= next_st;
            tmr  <= next_tmr;
            slot <= next_slot;
            emod <= next_emod;
            ech  <= next_ech;
            rv   <= next_rv;
            rch  <= next_rch;
            rdat <= next_rdat;
            sst  <= next_sst;
        end
    end

    // one request at a time selects a single mux input [R10] [R12]
    assign cv.start   = (st == AISS_REQ) && !sst;
    assign cv.is_exp  = (slot == 4'(BASE_CH)) && has_exp;
    assign cv.base_ch = slot[2:0];
    assign cv.exp_mod = emod;
    assign cv.exp_ch  = ech;

    assign o_res_valid  = rv;
    assign o_res_chan   = rch;
    assign o_res_data   = rdat;
    assign o_scan_start = sst;

    property p_period;
        @(posedge i_sys_clk) disable iff (!i_rstn)
        sst |-> ##1 !sst [*8];
    endproperty
    a_period: assert property (p_period) // [R08]
        else $error("scan ticks too close");

    property p_reset_ptr;
        @(posedge i_sys_clk) disable iff (!i_rstn)
        !has_exp |=> (emod == 3'h0 && ech == 4'h0);
    endproperty
    a_reset_ptr: assert property (p_reset_ptr) // [R04]
        else $error("pointer not parked without expanders");

    property p_adv;
        @(posedge i_sys_clk) disable iff (!i_rstn)
        (st == AISS_WAIT && i_done && slot == 4'(BASE_CH) && has_exp
         && ech != EXP_CH_LAST && $stable(i_num_exp))
        |=> ech == $past(ech) + 4'h1;
    endproperty
    a_adv: assert property (p_adv) // [R02]
        else $error("expander channel did not advance");

    property p_mod;
        @(posedge i_sys_clk) disable iff (!i_rstn)
        (st == AISS_WAIT && i_done && slot == 4'(BASE_CH)
         && ech == EXP_CH_LAST) |=> ech == 4'h0;
    endproperty
    a_mod: assert property (p_mod) // [R03]
        else $error("channel did not wrap after sixteen");

    property p_num;
        @(posedge i_sys_clk) disable iff (!i_rstn)
        rv |-> rch >= LCH_W'(1);
    endproperty
    a_num: assert property (p_num) // [R13]
        else $error("channel number zero");

    property p_one;
        @(posedge i_sys_clk) disable iff (!i_rstn)
        cv.start |=> !cv.start;
    endproperty
    a_one: assert property (p_one) // [R10]
        else $error("back to back requests");

    property p_emod;
        @(posedge i_sys_clk) disable iff (!i_rstn)
        has_exp && $stable(i_num_exp) |=> emod < i_num_exp;
    endproperty
    a_emod: assert property (p_emod) // [R11]
        else $error("module pointer beyond chain");

    property p_data;
        @(posedge i_sys_clk) disable iff (!i_rstn)
        (st == AISS_WAIT && i_done) |=> rv && rdat == $past(i_data);
    endproperty
    a_data: assert property (p_data) // [R14]
        else $error("result data mismatch");
endmodule
`default_nettype wire

// ### rtl/aiss_pkg.sv
// package for the analog input scan sequencer
// assumes a 125 MHz system clock
package aiss_pkg;
    localparam int CLK_HZ          = 125_000_000;
    localparam int BASE_CH         = 8;
    localparam int EXP_CH          = 16;
    localparam int MAX_EXP         = 7;
    localparam int RES_W           = 16;
    localparam int LCH_W           = 7;
    localparam int SCAN_US_NOEXP   = 2400;
    localparam int SCAN_US_EXP     = 2800;
    localparam int SCAN_CYC_NOEXP  = SCAN_US_NOEXP * (CLK_HZ / 1_000_000);
    localparam int SCAN_CYC_EXP    = SCAN_US_EXP * (CLK_HZ / 1_000_000);
    localparam int FIRST_EXP_LCH   = 9;
    localparam logic [2:0] SLOT_LAST_BASE = 3'h7;
    localparam logic [3:0] EXP_CH_LAST    = 4'hF;
endpackage

// ### rtl/aiss_conv_if.sv
// handshake between scan sequencer and its converter port block
// single clock domain
`timescale 1ns/1ps
`default_nettype none
interface aiss_conv_if;
    logic        start;
    logic        is_exp;
    logic [2:0]  base_ch;
    logic [2:0]  exp_mod;
    logic [3:0]  exp_ch;
    logic        done;
    logic [15:0] data;
    modport seq  (output start, is_exp, base_ch, exp_mod, exp_ch,
                  input done, data);
    modport port (input start, is_exp, base_ch, exp_mod, exp_ch,
                  output done, data);
endinterface
`default_nettype wire

// ### rtl/aiss_conv_port.sv
// converter port: issues one conversion request to the analog front end
// assumes the front end answers each request with one done pulse
`timescale 1ns/1ps
`default_nettype none
module aiss_conv_port (
    input  wire logic        i_sys_clk,
    input  wire logic        i_rstn,
    aiss_conv_if.port        cv,
    output logic             o_req,
    output logic             o_req_exp,
    output logic [2:0]       o_req_base_ch,
    output logic [2:0]       o_req_exp_mod,
    output logic [3:0]       o_req_exp_ch,
    input  wire logic        i_done,
    input  wire logic [15:0] i_data
);
    logic        req, next_req;

    always_comb begin
        next_req  = cv.start;
    end
    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            req  <= 1'b0;
        end else begin
            req  <= next_req;
        end
    end
    assign o_req         = req;
    assign o_req_exp     = cv.is_exp;
    assign o_req_base_ch = cv.base_ch;
    assign o_req_exp_mod = cv.exp_mod;
    assign o_req_exp_ch  = cv.exp_ch;
    assign cv.done       = i_done;
    assign cv.data       = i_data;
endmodule
`default_nettype wire

// ### bench/aiss_fe_model.sv
// front end model: answers each conversion request with one done pulse
// assumes requests arrive one at a time, select lines held until done
`timescale 1ns/1ps
`default_nettype none
module aiss_fe_model (
    // clock and reset
    input  wire logic        i_sys_clk,
    input  wire logic        i_rstn,
    // request side
    input  wire logic        i_req,
    // answer side
    output logic             o_done,
    output logic [15:0]      o_data
);
    int   wait_cyc;
    logic busy;

    initial begin
        o_done = 1'b0;
        o_data = 16'h0000;
        busy   = 1'b0;
    end

    always @(posedge i_sys_clk) begin
        o_done <= 1'b0;
        // data lines are not held outside an answer
        o_data <= ~o_data;
        if (!i_rstn) begin
            busy = 1'b0;
        end else if (i_req && !busy) begin
            // one request served at a time, select lines not modelled
            busy     = 1'b1;
            wait_cyc = ($urandom % 8 == 0) ? 12 : 1 + $urandom % 4;
        end else if (busy) begin
            wait_cyc--;
            if (wait_cyc == 0) begin
                busy   = 1'b0;
                o_done <= 1'b1;
                o_data <= 16'($urandom);
            end
        end
    end
endmodule
`default_nettype wire

// ### bench/tb_top.sv
// testbench for the scan sequencer with a front end model
// assumes short scan periods set through the sequencer parameters
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import aiss_pkg::*;
    localparam int PER0 = 200;
    localparam int PER1 = 240;
    logic        i_sys_clk = 1'b0;
    logic        i_rstn    = 1'b0;
    logic [2:0]  i_num_exp = 3'h0;
    logic        req, rexp, done, res_valid, scan_start;
    logic [2:0]  rbase, rmod;
    logic [3:0]  rch;
    logic [15:0] data, cap;
    logic [6:0]  res_chan;
    logic signed [15:0] res_data;
    int num_errors  = 0;
    int comparisons = 0;
    int cyc, last_start, rcount, emod, ech;
    bit first;

    always #4 i_sys_clk = ~i_sys_clk;

    aiss_seq #(.SCAN_NOEXP(PER0), .SCAN_EXP(PER1)) dut (
        .i_sys_clk(i_sys_clk), .i_rstn(i_rstn), .i_num_exp(i_num_exp),
        .o_req(req), .o_req_exp(rexp), .o_req_base_ch(rbase),
        .o_req_exp_mod(rmod), .o_req_exp_ch(rch), .i_done(done),
        .i_data(data), .o_res_valid(res_valid), .o_res_chan(res_chan),
        .o_res_data(res_data), .o_scan_start(scan_start));

    aiss_fe_model fe (.i_sys_clk(i_sys_clk), .i_rstn(i_rstn),
        .i_req(req), .o_done(done), .o_data(data));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                       input string what);
        comparisons++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH %0t %s got %0h exp %0h", $time, what, got,
                     exp);
        end
    endtask

    function automatic int next_chan(input int k);
        return (k < BASE_CH) ? k + 1 : FIRST_EXP_LCH + EXP_CH * emod + ech;
    endfunction

    always @(posedge i_sys_clk) begin
        cyc++;
        if (!i_rstn) begin
            first = 1;
            rcount = 0;
            emod = 0;
            ech = 0;
        end else begin
            if (req === 1'b1) begin
                chk(rexp, rcount == BASE_CH, "sel exp");
                if (rcount < BASE_CH)
                    chk(rbase, rcount, "sel base");
                else
                    chk({rmod, rch}, {emod[2:0], ech[3:0]}, "sel");
            end
            if (done === 1'b1) begin
                cap = data;
                chk(rexp, rcount == BASE_CH, "sel hold");
            end
            if (res_valid === 1'b1) begin
                chk(res_chan, next_chan(rcount), "chan");
                chk(res_data, $signed(cap), "data");
                if (rcount == BASE_CH) begin
                    ech = (ech + 1) % EXP_CH;
                    if (ech == 0)
                        emod = (emod + 1 == i_num_exp) ? 0 : emod + 1;
                end
                rcount++;
            end
            if (scan_start === 1'b1) begin
                if (!first) begin
                    chk(cyc - last_start, i_num_exp ? PER1 : PER0,
                        "period");
                    chk(rcount, i_num_exp ? 9 : 8, "count");
                end
                first = 0;
                last_start = cyc;
                rcount = 0;
            end
        end
    end

    task automatic run_cfg(input logic [2:0] n, input int scans);
        @(negedge i_sys_clk);
        i_rstn = 1'b0;
        i_num_exp = n;
        repeat (8) @(negedge i_sys_clk);
        i_rstn = 1'b1;
        repeat (scans * (n ? PER1 : PER0) + 20) @(negedge i_sys_clk);
    endtask

    task automatic finish_test;
        if (num_errors == 0 && comparisons > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    initial begin
        void'($urandom(32'h4ca0));
        run_cfg(3'h0, 3);
        run_cfg(3'h1, 18);
        run_cfg(3'h2, 34);
        run_cfg(3'h3, 20);
        run_cfg(3'h3, 3);
        run_cfg(3'($urandom_range(7, 0)), 4);
        run_cfg(3'h7, 114);
        finish_test;
    end

    initial begin
        repeat (60000) @(posedge i_sys_clk);
        num_errors++;
        finish_test;
    end
endmodule
`default_nettype wire
